// *** dmr_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module dmr_monitor #(
	parameter int SLOW_CYC = dmr_pkg::SLOW_CYC,
	parameter int DVBE_NOM = 0
) (
	input  wire logic                        MCLK,          // core clock
	input  wire logic                        RST_B,         // async reset
	input  wire logic                        CE,            // core clock enable
	input  wire logic                        ADC_CLK,       // converter clock
	input  wire logic                        ADC_VALID,     // slow sample strobe
	input  wire dmr_pkg::dmr_adc_word_type   ADC_WORD,      // slow sample
	input  wire logic                        MD_STB,        // photodiode sample strobe
	input  wire logic [dmr_pkg::MD_W-1:0]    MD_DATA,       // photodiode sample
	input  wire logic                        TX_ON,         // transmitter on
	input  wire logic                        TX_SHDN,       // shutdown indication
	input  wire dmr_pkg::dmr_laser_cfg_type  LASER_CFG,     // bias, mod, select
	input  wire logic                        AVG_CNT_BIT,   // 32 or 256 samples
	input  wire logic                        FOUR_AVG_EN,   // fourfold averaging
	input  wire dmr_pkg::dmr_temp_cal_type   DIE_CAL,       // die scale/offset
	input  wire dmr_pkg::dmr_temp_cal_type   BOARD_CAL,     // board scale/offset
	input  wire logic                        RSSI_SOURCED,  // current pulled out
	input  wire logic                        LOW_MASK,      // mask for low flag
	input  wire logic                        RD_STB,        // byte read strobe
	input  wire logic [dmr_pkg::ADDR_W-1:0]  RD_ADDR,       // byte address
	output logic [7:0]                       RD_DATA,       // read byte
	output logic                             RD_VALID,      // read answer
	output logic                             LOW_FLAG_IRQ,  // interrupt request
	output logic                             TOP_STATUS,    // summary bit
	output logic                             SENSE_SRC_EN,  // sensor current on
	output logic                             RETURN_GND_EN  // sensor return grounded
);
	localparam int SW = 21;
	localparam logic [SW-1:0] SLOW_LAST = SW'(SLOW_CYC - 1);
	localparam logic [11:0]   LASER_LAST = 12'(dmr_pkg::LASER_CYC - 1);

	// ---------------- link domain ----------------
	logic                        lrst_s1, lrst_b;
	logic                        ton_s1, ton_s2, avc_s1, avc_s2;
	logic                        ack_s1, ack_s2;
	logic                        req_s1, req_s2, req_s3;
	logic [19:0]                 md_acc, next_md_acc;
	logic [7:0]                  md_cnt, next_md_cnt;
	logic                        md_pend, next_md_pend;
	logic [dmr_pkg::MD_W-1:0]    md_word, next_md_word;
	dmr_pkg::dmr_adc_word_type   l_word, next_l_word;
	logic                        l_tog, next_l_tog;
	logic [19:0]                 md_sum;
	logic [7:0]                  md_last;

	// the link side leaves reset two of its own edges late, so a release near an
	// edge cannot leave half of its state running and half still in reset
	// reset release and level synchronisers into the link clock
	always_ff @(posedge ADC_CLK or negedge RST_B) begin
		if (!RST_B) begin
			{lrst_s1, lrst_b} <= 2'h0;
			{ton_s1, ton_s2, avc_s1, avc_s2, ack_s1, ack_s2} <= 6'h00;
		end else begin
			lrst_s1 <= 1'b1;
			lrst_b  <= lrst_s1;
			ton_s1  <= TX_ON;
			ton_s2  <= ton_s1;
			avc_s1  <= AVG_CNT_BIT;
			avc_s2  <= avc_s1;
			ack_s1  <= req_s3;
			ack_s2  <= ack_s1;
		end
	end

	// photodiode averaging and the word handed to the core
	always_comb begin
		next_md_acc  = md_acc;
		next_md_cnt  = md_cnt;
		next_md_pend = md_pend;
		next_md_word = md_word;
		next_l_word  = l_word;
		next_l_tog   = l_tog;
		md_sum  = md_acc + 20'(MD_DATA);
		md_last = avc_s2 ? dmr_pkg::MD_LAST_HI : dmr_pkg::MD_LAST_LO;
		// a word is posted only once the core acknowledged the last one
		if (l_tog == ack_s2) begin
			if (md_pend) begin
				next_l_word = {dmr_pkg::CH_PHOTO, 4'h0, md_word};
				next_l_tog  = ~l_tog;
				next_md_pend = 1'b0;
			end else if (ADC_VALID) begin
				next_l_word = ADC_WORD;
				next_l_tog  = ~l_tog;
			end
		end
		// a partial sum is dropped when the transmitter stops, never resumed later
		// samples count only while transmitting
		if (!ton_s2) begin
			next_md_acc = 20'h00000;
			next_md_cnt = 8'h00;
		end else if (MD_STB) begin
			if (md_cnt == md_last) begin
				next_md_word = avc_s2 ? md_sum[dmr_pkg::MD_SHIFT_HI +: dmr_pkg::MD_W]
				                      : md_sum[dmr_pkg::MD_SHIFT_LO +: dmr_pkg::MD_W];
				next_md_pend = 1'b1;
				next_md_acc  = 20'h00000;
				next_md_cnt  = 8'h00;
			end else begin
				next_md_acc = md_sum;
				next_md_cnt = md_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge ADC_CLK or negedge RST_B) begin
		if (!RST_B) begin
			md_acc  <= 20'h00000;
			md_cnt  <= 8'h00;
			md_pend <= 1'b0;
			md_word <= 12'h000;
			l_word  <= '0;
			l_tog   <= 1'b0;
		end else if (lrst_b) begin
			md_acc  <= next_md_acc;
			md_cnt  <= next_md_cnt;
			md_pend <= next_md_pend;
			md_word <= next_md_word;
			l_word  <= next_l_word;
			l_tog   <= next_l_tog;
		end
	end

	// ---------------- core domain ----------------
	logic                        sig_s1, sig_s2;
	logic                        ev;
	dmr_pkg::dmr_adc_word_type   cw;
	logic [dmr_pkg::RES_W-1:0]   res [dmr_pkg::N_RES];
	logic [dmr_pkg::RES_W-1:0]   next_res [dmr_pkg::N_RES];
	logic [dmr_pkg::RES_W-1:0]   pend [dmr_pkg::N_SLOW];
	logic [dmr_pkg::RES_W-1:0]   next_pend [dmr_pkg::N_SLOW];
	logic signed [17:0]          acc [dmr_pkg::N_SLOW];
	logic signed [17:0]          next_acc [dmr_pkg::N_SLOW];
	logic [1:0]                  cnt4, next_cnt4;
	logic [SW-1:0]               tmr, next_tmr;
	logic [11:0]                 ltmr, next_ltmr;
	logic [15:0]                 brd_lo, next_brd_lo;
	logic [23:0]                 bt, mt, est, lo_lim, hi_lim;
	logic                        lz_upd;

	// saturate to a signed 16-bit temperature word
	function automatic logic [15:0] sat16(input logic signed [33:0] v);
		if (v > 34'sh7fff)
			sat16 = 16'h7fff;
		else if (v < -34'sh8000)
			sat16 = 16'h8000;
		else
			sat16 = v[15:0];
	endfunction : sat16

	// scale is unsigned with fixed fraction, offset is signed 1/256 degree
	function automatic logic [15:0] tcal(input logic [15:0] raw, input dmr_pkg::dmr_temp_cal_type c);
		logic signed [33:0] p;
		p = ($signed({{18{raw[15]}}, raw}) * $signed({18'h00000, c.scale})) >>> dmr_pkg::TEMP_FRAC;
		p = p + $signed({{18{c.offset[15]}}, c.offset});
		tcal = sat16(p);
	endfunction : tcal

	// temperatures average as signed values, everything else unsigned
	function automatic logic signed [17:0] ext(input logic [15:0] v, input int i);
		if (i == dmr_pkg::IX_DIE || i == dmr_pkg::IX_BOARD)
			ext = $signed({{2{v[15]}}, v});
		else
			ext = $signed({2'h0, v});
	endfunction : ext

	// toggle handshake and signal-strength pin synchronisers
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			{req_s1, req_s2, req_s3, sig_s1, sig_s2} <= 5'h00;
		end else if (CE) begin
			req_s1 <= l_tog;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			sig_s1 <= RSSI_SOURCED;
			sig_s2 <= sig_s1;
		end
	end
	// the word is held still by the link side until req_s3 returns as ack
	assign ev = req_s2 ^ req_s3;
	assign cw = l_word;

	// result formatting, cadence and laser estimate
	always_comb begin
		next_res    = res;
		next_pend   = pend;
		next_acc    = acc;
		next_cnt4   = cnt4;
		next_brd_lo = brd_lo;
		next_tmr    = (tmr == SLOW_LAST) ? '0 : tmr + 1'b1;
		next_ltmr   = (ltmr == LASER_LAST) ? 12'h000 : ltmr + 12'h001;
		lz_upd      = (ltmr == LASER_LAST);
		if (ev) begin
			case (cw.chan)
				// supplies keep the raw 12-bit code
				dmr_pkg::CH_SUP_A:  next_pend[dmr_pkg::IX_SUP_A]  = 16'(cw.data[dmr_pkg::SUP_W-1:0]);
				dmr_pkg::CH_TX_SUP: next_pend[dmr_pkg::IX_TX_SUP] = 16'(cw.data[dmr_pkg::SUP_W-1:0]);
				dmr_pkg::CH_TX_OUT: next_pend[dmr_pkg::IX_TX_OUT] =
					cw.data[15] ? 16'h0000 : 16'(cw.data[dmr_pkg::SUP_W-1:0]);
				dmr_pkg::CH_SPARE:  next_pend[dmr_pkg::IX_SPARE] =
					cw.data[15] ? 16'h0000 : 16'(cw.data[dmr_pkg::SUP_W-1:0]);
				dmr_pkg::CH_RSSI:   next_pend[dmr_pkg::IX_RSSI] = cw.data[15] ? 16'h0000 : cw.data;
				// signed degrees over a 1/256 fraction
				dmr_pkg::CH_DIE:    next_pend[dmr_pkg::IX_DIE] = tcal(cw.data, DIE_CAL);
				dmr_pkg::CH_BRD_LO: next_brd_lo = cw.data;
				// the second current doubles the series drop, subtract the excess
				dmr_pkg::CH_BRD_HI: next_pend[dmr_pkg::IX_BOARD] = tcal(sat16(
					34'($signed({{18{brd_lo[15]}}, brd_lo}) * 2)
					- $signed({{18{cw.data[15]}}, cw.data}) + 34'(DVBE_NOM)), BOARD_CAL);
				// optical power skips the slow tick, so it refreshes with every finished average
				// optical power range
				dmr_pkg::CH_PHOTO: begin
					if (cw.data[dmr_pkg::MD_W-1:0] < dmr_pkg::OPT_MIN)
						next_res[dmr_pkg::IX_OPT] = 16'(dmr_pkg::OPT_MIN);
					else if (cw.data[dmr_pkg::MD_W-1:0] > dmr_pkg::OPT_MAX)
						next_res[dmr_pkg::IX_OPT] = 16'(dmr_pkg::OPT_MAX);
					else
						next_res[dmr_pkg::IX_OPT] = 16'(cw.data[dmr_pkg::MD_W-1:0]);
				end
				default: ;
			endcase
		end
		// slow results publish on the 10 ms tick, every fourth when averaging
		if (tmr == SLOW_LAST) begin
			next_cnt4 = FOUR_AVG_EN ? cnt4 + 2'h1 : 2'h0;
			for (int i = 0; i < dmr_pkg::N_SLOW; i++) begin
				if (!FOUR_AVG_EN) begin
					next_res[i] = pend[i];
					next_acc[i] = 18'sh0;
				end else if (cnt4 == dmr_pkg::AVG4_LAST) begin
					next_res[i] = 16'((acc[i] + ext(pend[i], i)) >>> dmr_pkg::AVG4_SHIFT);
					next_acc[i] = 18'sh0;
				end else begin
					next_acc[i] = acc[i] + ext(pend[i], i);
				end
			end
		end
		// estimate in 58.5uA steps, 4/12.8 taken as 5/16
		bt = 24'(LASER_CFG.bias) + dmr_pkg::BIAS_OFS;
		mt = 24'(LASER_CFG.modu) + dmr_pkg::MOD_OFS;
		// select picks the DC or average estimate
		if (!LASER_CFG.sel) begin
			est    = bt + ((mt * dmr_pkg::DC_MUL) >> dmr_pkg::DC_SHIFT);
			lo_lim = dmr_pkg::DC_MIN;
			hi_lim = dmr_pkg::DC_MAX;
		end else begin
			est    = bt + ((mt * dmr_pkg::AVG_MUL) >> dmr_pkg::AVG_SHIFT);
			lo_lim = dmr_pkg::AVG_MIN;
			hi_lim = dmr_pkg::AVG_MAX;
		end
		if (est < lo_lim)
			est = lo_lim;
		else if (est > hi_lim)
			est = hi_lim;
		if (lz_upd && !TX_SHDN)
			next_res[dmr_pkg::IX_LASER] = est[dmr_pkg::RES_W-1:0];
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < dmr_pkg::N_RES; i++)
				res[i] <= 16'h0000;
			for (int i = 0; i < dmr_pkg::N_SLOW; i++) begin
				pend[i] <= 16'h0000;
				acc[i]  <= 18'sh0;
			end
			cnt4   <= 2'h0;
			tmr    <= '0;
			ltmr   <= 12'h000;
			brd_lo <= 16'h0000;
		end else if (CE) begin
			res    <= next_res;
			pend   <= next_pend;
			acc    <= next_acc;
			cnt4   <= next_cnt4;
			tmr    <= next_tmr;
			ltmr   <= next_ltmr;
			brd_lo <= next_brd_lo;
		end
	end

	// ---------------- read port, flag, pins ----------------
	logic [7:0] shadow, next_shadow, next_rd_data;
	logic       flag, next_flag, clr;
	logic [3:0] rd_idx;
	logic       in_map;
	logic [7:0] cur_lo;

	always_comb begin
		rd_idx       = RD_ADDR[dmr_pkg::ADDR_W-1:1];
		in_map       = (rd_idx < 4'(dmr_pkg::N_RES));
		cur_lo       = in_map ? res[rd_idx][7:0] : 8'h00;
		next_shadow  = shadow;
		next_rd_data = 8'h00;
		clr          = RD_STB && (RD_ADDR == dmr_pkg::ADDR_STATUS);
		// a source still present survives the clearing read, so no event is lost
		// sticky, set wins over the read clear
		next_flag    = sig_s2 | (flag & ~clr);
		if (RD_STB) begin
			if (clr)
				next_rd_data[dmr_pkg::ST_LOW_BIT] = flag;
			else if (in_map && !RD_ADDR[0]) begin
				// upper read captures its lower byte from the same value
				next_rd_data = res[rd_idx][15:8];
				next_shadow  = cur_lo;
			end else if (in_map)
				next_rd_data = shadow;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			RD_DATA       <= 8'h00;
			RD_VALID      <= 1'b0;
			shadow        <= 8'h00;
			flag          <= 1'b0;
			LOW_FLAG_IRQ  <= 1'b0;
			TOP_STATUS    <= 1'b0;
			SENSE_SRC_EN  <= 1'b0;
			RETURN_GND_EN <= 1'b0;
		end else if (CE) begin
			RD_DATA       <= next_rd_data;
			RD_VALID      <= RD_STB;
			shadow        <= next_shadow;
			flag          <= next_flag;
			LOW_FLAG_IRQ  <= flag & ~LOW_MASK;
			TOP_STATUS    <= flag & ~LOW_MASK;
			// source sense current, ground the return once running
			SENSE_SRC_EN  <= 1'b1;
			RETURN_GND_EN <= 1'b1;
		end
	end

	// ---------------- checks ----------------
	a_laser_dc_range: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CE && lz_upd && !TX_SHDN && !LASER_CFG.sel) |=> (res[dmr_pkg::IX_LASER] >= 16'h0011
		&& res[dmr_pkg::IX_LASER] <= 16'h04af)) else $error("dc laser report out of range");
	a_laser_avg_range: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CE && lz_upd && !TX_SHDN && LASER_CFG.sel) |=> (res[dmr_pkg::IX_LASER] >= 16'h002b
		&& res[dmr_pkg::IX_LASER] <= 16'h0807)) else $error("average laser report out of range");
	a_laser_hold: assert property (@(posedge MCLK) disable iff (!RST_B)
		TX_SHDN |=> (res[dmr_pkg::IX_LASER] == $past(res[dmr_pkg::IX_LASER])))
		else $error("laser report moved during shutdown");
	a_opt_range: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CE && ev && cw.chan == dmr_pkg::CH_PHOTO) |=> (res[dmr_pkg::IX_OPT] >= 16'h0020
		&& res[dmr_pkg::IX_OPT] <= 16'h0ff0)) else $error("optical power out of range");
	a_flag_sticky: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CE && sig_s2) |=> flag ##1 (!$past(CE) || $past(LOW_MASK) || LOW_FLAG_IRQ))
		else $error("low flag lost or not propagated");
	a_mask_gate: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CE && LOW_MASK) |=> (!LOW_FLAG_IRQ && !TOP_STATUS)) else $error("masked flag propagated");
	a_block_pair: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CE && RD_STB && in_map && !RD_ADDR[0]) ##1 (CE && RD_STB && RD_ADDR == $past(RD_ADDR) + 5'h01)
		|=> (RD_DATA == $past(cur_lo, 2))) else $error("block read mixed halves");
	a_neg_clamp: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CE && ev && cw.chan == dmr_pkg::CH_SPARE && cw.data[15]) |=> (pend[dmr_pkg::IX_SPARE] == 16'h0000))
		else $error("negative auxiliary reading not clamped");
	a_opt_hold: assert property (@(posedge MCLK) disable iff (!RST_B)
		!(CE && ev && cw.chan == dmr_pkg::CH_PHOTO) |=> $stable(res[dmr_pkg::IX_OPT]))
		else $error("optical power moved without a finished average");
	a_avg_cadence: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CE && tmr == SLOW_LAST && FOUR_AVG_EN && cnt4 != dmr_pkg::AVG4_LAST)
		|=> $stable(res[dmr_pkg::IX_SUP_A]))
		else $error("averaged supply result published early");
endmodule : dmr_monitor
`default_nettype wire

// *** dmr_pkg.sv ***
// How it works
// - three supply results are raw unsigned 12-bit codes, 4.656V full scale.
// - laser report shows DC estimate when select is 0, average when 1.
// - DC estimate is (bias+12) plus (mod+16)*4 divided by 12.8.
// - DC estimate is clamped between 17 and 1199.
// - average estimate is (bias+12) plus 0.484 times (mod+16)*4.
// - average estimate is clamped between 43 and 2055.
// - laser report holds its last value while transmitter shutdown is high.
// - optical power is a 12-bit result, 977nA per count.
// - optical power updates per finished average of 32 or 256 samples, transmitter on.
// - optical power is clamped between 32 and 4080.
// - current pulled out of signal-strength input raises the sticky low flag.
// - auxiliary, output-stage supply and signal strength clamp negatives to zero.
// - temperature upper byte is signed degrees, lower byte 1/256 fraction.
// - user scale and offset are applied to raw temperature before loading.
// - sensor pin sources current and return pin is grounded in operation.
// - board temperature cancels series resistance error automatically.
// - the low flag is maskable; masked it latches but does not propagate.
package dmr_pkg;
	localparam int CH_W      = 4;
	localparam int ADC_W     = 16;
	localparam int RES_W     = 16;
	localparam int SUP_W     = 12;
	localparam int MD_W      = 12;
	localparam int N_RES     = 9;
	localparam int N_SLOW    = 7;
	localparam int ADDR_W    = 5;
	// adc channel codes
	localparam logic [CH_W-1:0] CH_SUP_A  = 4'h0;
	localparam logic [CH_W-1:0] CH_TX_SUP = 4'h1;
	localparam logic [CH_W-1:0] CH_TX_OUT = 4'h2;
	localparam logic [CH_W-1:0] CH_SPARE  = 4'h3;
	localparam logic [CH_W-1:0] CH_RSSI   = 4'h4;
	localparam logic [CH_W-1:0] CH_DIE    = 4'h5;
	localparam logic [CH_W-1:0] CH_BRD_LO = 4'h6;
	localparam logic [CH_W-1:0] CH_BRD_HI = 4'h7;
	localparam logic [CH_W-1:0] CH_PHOTO  = 4'h8;
	// result slots; byte address is slot*2 (upper) and slot*2+1 (lower)
	localparam int IX_SUP_A  = 0;
	localparam int IX_TX_SUP = 1;
	localparam int IX_TX_OUT = 2;
	localparam int IX_SPARE  = 3;
	localparam int IX_RSSI   = 4;
	localparam int IX_DIE    = 5;
	localparam int IX_BOARD  = 6;
	localparam int IX_LASER  = 7;
	localparam int IX_OPT    = 8;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h12;
	localparam int ST_LOW_BIT = 0;
	// laser current estimate, units of 58.5uA
	localparam logic [23:0] BIAS_OFS  = 24'h00000c;
	localparam logic [23:0] MOD_OFS   = 24'h000010;
	localparam logic [23:0] DC_MUL    = 24'h000005;
	localparam int          DC_SHIFT  = 4;
	localparam logic [23:0] AVG_MUL   = 24'h0007be;
	localparam int          AVG_SHIFT = 10;
	localparam logic [23:0] DC_MIN    = 24'h000011;
	localparam logic [23:0] DC_MAX    = 24'h0004af;
	localparam logic [23:0] AVG_MIN   = 24'h00002b;
	localparam logic [23:0] AVG_MAX   = 24'h000807;
	// optical power
	localparam logic [MD_W-1:0] OPT_MIN = 12'h020;
	localparam logic [MD_W-1:0] OPT_MAX = 12'hff0;
	localparam logic [7:0] MD_LAST_LO  = 8'h1f;
	localparam logic [7:0] MD_LAST_HI  = 8'hff;
	localparam int         MD_SHIFT_LO = 5;
	localparam int         MD_SHIFT_HI = 8;
	// timing
	localparam int CLK_NS    = 8;
	localparam int LASER_NS  = 26000;
	localparam int LASER_CYC = LASER_NS / CLK_NS;
	localparam int SLOW_US   = 10000;
	localparam int SLOW_CYC  = SLOW_US * 1000 / CLK_NS;
	localparam logic [1:0] AVG4_LAST = 2'h3;
	localparam int AVG4_SHIFT = 2;
	localparam int TEMP_FRAC  = 14;
	typedef struct packed {
		logic [CH_W-1:0]  chan;
		logic [ADC_W-1:0] data;
	} dmr_adc_word_type;
	typedef struct packed {
		logic [9:0] bias;
		logic [8:0] modu;
		logic       sel;
	} dmr_laser_cfg_type;
	typedef struct packed {
		logic [15:0] scale;
		logic [15:0] offset;
	} dmr_temp_cal_type;
endpackage : dmr_pkg

// *** dmr_adc_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module dmr_adc_model (
	input  wire logic                    ADC_CLK,    // converter clock
	output var logic                     ADC_VALID,  // slow sample strobe
	output var dmr_pkg::dmr_adc_word_type ADC_WORD,  // slow sample
	output var logic                     MD_STB,     // photodiode strobe
	output var logic [11:0]              MD_DATA     // photodiode sample
);
	// idle values at time zero
	initial begin
		ADC_VALID = 1'b0;
		ADC_WORD  = 20'h0;
		MD_STB    = 1'b0;
		MD_DATA   = 12'h0;
	end
	// one word per call, then 12 idle link clocks for the handshake; the bus shows the inverse once released,
	// so a design that samples late never sees a held copy
	task automatic send_word(input logic [3:0] ch, input logic [15:0] d);
		@(posedge ADC_CLK);
		ADC_VALID <= 1'b1;
		ADC_WORD  <= {ch, d};
		@(posedge ADC_CLK);
		ADC_VALID <= 1'b0;
		ADC_WORD  <= ~{ch, d};
		repeat (12) @(posedge ADC_CLK);
	endtask : send_word
	// photodiode samples; gap sets a prompt or slow stream
	task automatic send_md(input int n, input logic [11:0] v, input int gap);
		repeat (n) begin
			@(posedge ADC_CLK);
			MD_STB  <= 1'b1;
			MD_DATA <= v;
			@(posedge ADC_CLK);
			MD_STB  <= 1'b0;
			MD_DATA <= ~v;
			repeat (gap) @(posedge ADC_CLK);
		end
		repeat (12) @(posedge ADC_CLK);
	endtask : send_md
endmodule : dmr_adc_model
`default_nettype wire

// *** ddm_monitor_readout_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module ddm_monitor_readout_tb;
	logic mclk, adc_clk, rst_b, tx_on, tx_shdn, avg_cnt_bit, rssi_sourced, low_mask, rd_stb, four_avg_en;
	logic adc_valid, md_stb, rd_valid, low_flag_irq, top_status, sense_src_en, return_gnd_en;
	dmr_pkg::dmr_adc_word_type  adc_word;
	dmr_pkg::dmr_laser_cfg_type laser_cfg;
	dmr_pkg::dmr_temp_cal_type  die_cal, board_cal;
	logic [11:0] md_data;
	logic [4:0]  rd_addr;
	logic [7:0]  rd_data;
	logic [15:0] v;
	int          n_fail, cmp_count;
	// laser cases: dc min, mid, max then average min, mid, max
	logic [9:0]  lb [6] = '{10'h000, 10'h064, 10'h3ff, 10'h000, 10'h064, 10'h3ff};
	logic [8:0]  lm [6] = '{9'h000, 9'h064, 9'h1ff, 9'h000, 9'h064, 9'h1ff};
	logic [15:0] le [6] = '{16'h0011, 16'h0094, 16'h04af, 16'h002b, 16'h0150, 16'h0807};

	dmr_monitor #(.SLOW_CYC(64), .DVBE_NOM(0)) u_dmr_monitor (
		.MCLK(mclk), .RST_B(rst_b), .CE(1'b1), .ADC_CLK(adc_clk), .ADC_VALID(adc_valid),
		.ADC_WORD(adc_word), .MD_STB(md_stb), .MD_DATA(md_data), .TX_ON(tx_on), .TX_SHDN(tx_shdn),
		.LASER_CFG(laser_cfg), .AVG_CNT_BIT(avg_cnt_bit), .FOUR_AVG_EN(four_avg_en), .DIE_CAL(die_cal),
		.BOARD_CAL(board_cal), .RSSI_SOURCED(rssi_sourced), .LOW_MASK(low_mask), .RD_STB(rd_stb),
		.RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid), .LOW_FLAG_IRQ(low_flag_irq),
		.TOP_STATUS(top_status), .SENSE_SRC_EN(sense_src_en), .RETURN_GND_EN(return_gnd_en));
	dmr_adc_model u_dmr_adc_model (.ADC_CLK(adc_clk), .ADC_VALID(adc_valid), .ADC_WORD(adc_word),
		.MD_STB(md_stb), .MD_DATA(md_data));

	// core clock 8 ns; link clock 15 ns with its own phase
	always #4 mclk = ~mclk;
	always begin
		#8 adc_clk = 1'b1;
		#7 adc_clk = 1'b0;
	end
	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// n consecutive byte reads from a; answers are gathered in order
	task automatic rd(input logic [4:0] a, input int n, output logic [15:0] val);
		int got;
		got = 0;
		val = 16'h0;
		for (int i = 0; i < n + 3; i++) begin
			@(posedge mclk);
			rd_stb  <= (i < n);
			rd_addr <= a + 5'(i);
			#1;
			if (rd_valid === 1'b1) begin
				val = {val[7:0], rd_data};
				got++;
			end
		end
		chk(16'(got), 16'(n));
	endtask : rd
	// upper then lower byte of one slot in a single block read
	task automatic rd_res(input int s, input logic [15:0] exp);
		rd(5'(2 * s), 2, v);
		chk(v, exp);
	endtask : rd_res
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	// a hang counts as a mismatch
	initial begin
		repeat (90000) @(posedge mclk);
		n_fail++;
		stop_test();
	end
	// main sequence
	initial begin
		{mclk, adc_clk, rst_b, tx_shdn, avg_cnt_bit, rssi_sourced, low_mask, rd_stb} = 8'h0;
		{tx_on, four_avg_en, rd_addr} = 7'h00;
		n_fail    = 0;
		cmp_count = 0;
		tx_on     = 1'b1;
		laser_cfg = 20'h0;
		die_cal   = {16'h4000, 16'h0100};
		board_cal = {16'h4000, 16'h0000};
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk({14'h0, sense_src_en, return_gnd_en}, 16'h0003);
		for (int s = 0; s < dmr_pkg::N_RES; s++) rd_res(s, 16'h0000);
		rd(5'h13, 1, v);
		chk(v, 16'h0000);
		u_dmr_adc_model.send_word(dmr_pkg::CH_SUP_A, 16'h0abc);
		u_dmr_adc_model.send_word(dmr_pkg::CH_TX_SUP, 16'h0fff);
		for (int c = 2; c < 5; c++) u_dmr_adc_model.send_word(4'(c), 16'h8123);
		u_dmr_adc_model.send_word(dmr_pkg::CH_DIE, 16'h1234);
		u_dmr_adc_model.send_word(dmr_pkg::CH_BRD_LO, 16'h0200);
		u_dmr_adc_model.send_word(dmr_pkg::CH_BRD_HI, 16'h0300);
		repeat (150) @(posedge mclk);
		rd_res(dmr_pkg::IX_SUP_A, 16'h0abc);
		rd_res(dmr_pkg::IX_TX_SUP, 16'h0fff);
		for (int s = 2; s < 5; s++) rd_res(s, 16'h0000);
		rd_res(dmr_pkg::IX_DIE, 16'h1334);
		rd_res(dmr_pkg::IX_BOARD, 16'h0100);
		// a new conversion between upper and lower read must not tear
		rd(5'h00, 1, v);
		chk(v, 16'h000a);
		u_dmr_adc_model.send_word(dmr_pkg::CH_SUP_A, 16'h0def);
		repeat (150) @(posedge mclk);
		rd(5'h01, 1, v);
		chk(v, 16'h00bc);
		rd_res(dmr_pkg::IX_SUP_A, 16'h0def);
		// fourfold averaging settles within two windows of four ticks
		four_avg_en <= 1'b1;
		u_dmr_adc_model.send_word(dmr_pkg::CH_SUP_A, 16'h0100);
		repeat (700) @(posedge mclk);
		rd_res(dmr_pkg::IX_SUP_A, 16'h0100);
		// the reader may average repeated reads; a held result reads the same
		rd_res(dmr_pkg::IX_SUP_A, 16'h0100);
		u_dmr_adc_model.send_md(32, 12'h010, 1);
		rd_res(dmr_pkg::IX_OPT, 16'h0020);
		u_dmr_adc_model.send_md(32, 12'hfff, 3);
		rd_res(dmr_pkg::IX_OPT, 16'h0ff0);
		avg_cnt_bit <= 1'b1;
		u_dmr_adc_model.send_md(256, 12'h123, 1);
		rd_res(dmr_pkg::IX_OPT, 16'h0123);
		tx_on <= 1'b0;
		u_dmr_adc_model.send_md(256, 12'h800, 1);
		rd_res(dmr_pkg::IX_OPT, 16'h0123);
		for (int i = 0; i < 6; i++) begin
			laser_cfg <= {lb[i], lm[i], 1'(i >= 3)};
			repeat (3400) @(posedge mclk);
			rd_res(dmr_pkg::IX_LASER, le[i]);
		end
		// shutdown freezes the report although the settings move
		tx_shdn   <= 1'b1;
		laser_cfg <= 20'h0;
		repeat (3400) @(posedge mclk);
		rd_res(dmr_pkg::IX_LASER, 16'h0807);
		tx_shdn <= 1'b0;
		repeat (3400) @(posedge mclk);
		rd_res(dmr_pkg::IX_LASER, 16'h0011);
		low_mask     <= 1'b1;
		rssi_sourced <= 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		chk({14'h0, low_flag_irq, top_status}, 16'h0000);
		rd(dmr_pkg::ADDR_STATUS, 1, v);
		chk(v, 16'h0001);
		rssi_sourced <= 1'b0;
		repeat (6) @(posedge mclk);
		rd(dmr_pkg::ADDR_STATUS, 1, v);
		chk(v, 16'h0001);
		rd(dmr_pkg::ADDR_STATUS, 1, v);
		chk(v, 16'h0000);
		low_mask     <= 1'b0;
		rssi_sourced <= 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		chk({14'h0, low_flag_irq, top_status}, 16'h0003);
		stop_test();
	end
endmodule : ddm_monitor_readout_tb
`default_nettype wire
